// >>> rtl/cdc_pkg.sv
// Constants, types and helpers shared by the clock domain control block
package cdc_pkg;

  // System clock
  localparam int          CLK_PERIOD_NS     = 10;
  localparam longint      CLK_FREQ_HZ       = 100_000_000;

  // Multiplier: reference times a fixed ratio gives the 48 MHz domain
  localparam longint      REF_FREQ_HZ       = 14_318_180;
  localparam longint      GEN_MULT_NUM      = 352;
  localparam longint      GEN_MULT_DEN      = 105;
  localparam longint      GEN_FREQ_HZ       = REF_FREQ_HZ * GEN_MULT_NUM / GEN_MULT_DEN;
  localparam int          GEN_ACC_W         = 28;
  localparam logic [27:0] GEN_ACC_MOD       = 28'(CLK_FREQ_HZ);
  localparam logic [27:0] GEN_ACC_STEP      = 28'(2 * GEN_FREQ_HZ);

  // Lock delay of the multiplier, least time, rounded up
  localparam int          GEN_LOCK_DELAY_NS = 10_000;
  localparam int          GEN_LOCK_CYC_RAW  = (GEN_LOCK_DELAY_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int          GEN_LOCK_CYCLES   = (GEN_LOCK_CYC_RAW < 1) ? 1 : GEN_LOCK_CYC_RAW;
  localparam int          GEN_LOCK_W        = 12;
  localparam logic [11:0] GEN_LOCK_LAST     = 12'(GEN_LOCK_CYCLES - 1);

  // Clock filter windows: least period rounds up, longest rounds down
  localparam int          FILT_CNT_W        = 13;
  localparam int          SLOW_PER_MIN_NS   = 28_000;
  localparam int          SLOW_PER_MAX_NS   = 33_000;
  localparam int          SLOW_PER_MIN_CYC  = (SLOW_PER_MIN_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int          SLOW_PER_MAX_CYC  = SLOW_PER_MAX_NS / CLK_PERIOD_NS;
  localparam int          REF_PER_MIN_NS    = 50;
  localparam int          REF_PER_MAX_NS    = 90;
  localparam int          REF_PER_MIN_CYC   = (REF_PER_MIN_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int          REF_PER_MAX_CYC   = REF_PER_MAX_NS / CLK_PERIOD_NS;
  localparam int          FILT_GOOD_EDGES   = 4;

  // Supply bit positions in the synchroniser vector
  localparam int          SUPPLY_MAIN       = 0;
  localparam int          SUPPLY_STANDBY    = 1;
  localparam int          SUPPLY_CORE       = 2;

  // Reset values
  localparam logic        RST_LEVEL         = 1'b0;
  localparam logic [2:0]  RST_SUPPLY        = 3'h0;

  // Multiplier states
  typedef enum logic [1:0] {
    GEN_OFF,
    GEN_LOCKING,
    GEN_RUN
  } cdc_gen_state_t;

  // Settled level: follows the pin once stages two and three agree
  function automatic logic cdc_settle(input logic cur, input logic s2, input logic s3);
    return (s2 == s3) ? s3 : cur;
  endfunction

endpackage

// >>> rtl/cdc_filter_if.sv
// Interface between a clock filter and its user
`timescale 1ns/1ps
interface cdc_filter_if;
  logic arm;
  logic level;
  logic rise;
  logic valid;
  modport filt (input arm, output level, output rise, output valid);
  modport user (output arm, input level, input rise, input valid);
endinterface

// >>> rtl/cdc_clock_filter.sv
// Clock filter: settles a clock pin and flags it valid when its period is sane
`timescale 1ns/1ps
module cdc_clock_filter #(
  parameter int MIN_CYC = 5,
  parameter int MAX_CYC = 9,
  parameter int GOOD    = 4,
  parameter int CNT_W   = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw clock pin
  input wire logic pin,
  // User side
  cdc_filter_if.filt fif
);

  localparam logic [CNT_W-1:0] MIN_P   = CNT_W'(MIN_CYC);
  localparam logic [CNT_W-1:0] MAX_P   = CNT_W'(MAX_CYC);
  localparam logic [CNT_W-1:0] OVERDUE = CNT_W'(MAX_CYC + 1);
  localparam logic [3:0]       GOOD_L  = 4'(GOOD - 1);

  logic             s1;
  logic             s2;
  logic             s3;
  logic             next_level;
  logic [CNT_W-1:0] period_cnt;
  logic [3:0]       good_cnt;

  // Three-stage pin synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= cdc_pkg::RST_LEVEL;
      s2 <= cdc_pkg::RST_LEVEL;
      s3 <= cdc_pkg::RST_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign next_level = cdc_pkg::cdc_settle(fif.level, s2, s3);

  // Settled level and rising edge pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fif.level <= cdc_pkg::RST_LEVEL;
      fif.rise  <= 1'b0;
    end else begin
      fif.level <= next_level;
      fif.rise  <= next_level && !fif.level;
    end
  end

  // Cycles since the last rising edge, saturating once overdue
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_cnt <= '0;
    end else if (!fif.arm || fif.rise) begin
      period_cnt <= '0;
    end else if (period_cnt != OVERDUE) begin
      period_cnt <= period_cnt + CNT_W'(1);
    end
  end

  // Valid after GOOD in-window periods, dropped on any bad or missing edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      good_cnt  <= '0;
      fif.valid <= 1'b0;
    end else if (!fif.arm) begin
      good_cnt  <= '0;
      fif.valid <= 1'b0;
    end else if (fif.rise) begin
      if (period_cnt >= MIN_P && period_cnt <= MAX_P) begin
        if (good_cnt != GOOD_L) begin
          good_cnt <= good_cnt + 4'h1;
        end else begin
          fif.valid <= 1'b1; // see [R10]
        end
      end else begin
        good_cnt  <= '0;
        fif.valid <= 1'b0;
      end
    end else if (period_cnt == OVERDUE) begin
      good_cnt  <= '0;
      fif.valid <= 1'b0; // see [R10]
    end
  end

  // A stalled clock takes validity away
  property p_overdue_drop;
    @(posedge clk) disable iff (!rst_b)
      (fif.arm && period_cnt == OVERDUE) |=> !fif.valid;
  endproperty
  a_overdue_drop: assert property (p_overdue_drop) else $error("filter valid after stall"); // see [R10]

endmodule

// >>> rtl/cdc_clock_control.sv
// Clock domain control: bus, 48 MHz multiplier and 32 KHz standby domains
//
// Contract
// [R01] Bus and 48 MHz domains run only while the main supply is up.
// [R02] The outside world gives a valid bus clock before main power-up reset ends.
// [R03] Software waits for a valid reference before setting the generator enable.
// [R04] Setting the generator enable starts the clock multiplier.
// [R05] The multiplier output stays low until its lock delay has passed.
// [R06] The valid flag reads 0 while locking and 1 once the 48 MHz domain toggles.
// [R07] Software polls the valid flag before starting 48 MHz users.
// [R08] The 48 MHz rate is the reference rate times a fixed ratio.
// [R09] The 32 KHz domain runs while standby and core supplies are up.
// [R10] The 32 KHz domain is held low until the slow clock is seen valid.
// [R11] Wake-up, GPIO and glue logic take the 32 KHz domain from the slow input.
// [R12] Bus interface and configuration run on the bus clock domain.
// [R13] Serial, parallel, floppy, keyboard and fan monitor use the 48 MHz domain.
// [R14] The valid flag passes two stages before software sees it.
`timescale 1ns/1ps
module cdc_clock_control (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Supply good pins
  input  wire logic main_supply,
  input  wire logic standby_supply,
  input  wire logic core_supply,
  // Clock pins
  input  wire logic reference_clock_input,
  input  wire logic slow_clock_input,
  // Configuration
  input  wire logic generator_enable,
  // Bus domain
  output logic      bus_domain_run,
  // 48 MHz domain
  output logic      gen_domain_run,
  output logic      gen_domain_clk,
  output logic      generator_clock_valid,
  // 32 KHz domain
  output logic      slow_domain_run,
  output logic      slow_domain_clk,
  output logic      slow_clock_valid
);

  logic                          rst_q1;
  logic                          rst_sync_b;
  logic [2:0]                    sup_s1;
  logic [2:0]                    sup_s2;
  logic [2:0]                    sup_s3;
  logic [2:0]                    sup_ok;
  logic                          main_ok;
  logic                          slow_ok;
  cdc_pkg::cdc_gen_state_t       state;
  cdc_pkg::cdc_gen_state_t       next_state;
  logic [cdc_pkg::GEN_LOCK_W-1:0] lock_cnt;
  logic [cdc_pkg::GEN_ACC_W-1:0] acc;
  logic [cdc_pkg::GEN_ACC_W:0]   acc_sum;
  logic                          tick;
  logic                          gen_running;
  logic                          valid_q1;

  cdc_filter_if ref_if ();
  cdc_filter_if slow_if ();

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_sync_b <= rst_q1;
    end
  end

  // Supply pins pass three flops
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sup_s1 <= cdc_pkg::RST_SUPPLY;
      sup_s2 <= cdc_pkg::RST_SUPPLY;
      sup_s3 <= cdc_pkg::RST_SUPPLY;
    end else begin
      sup_s1 <= {core_supply, standby_supply, main_supply};
      sup_s2 <= sup_s1;
      sup_s3 <= sup_s2;
    end
  end

  // Settled supply levels
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sup_ok <= cdc_pkg::RST_SUPPLY;
    end else begin
      for (int i = 0; i < 3; i++) begin
        sup_ok[i] <= cdc_pkg::cdc_settle(sup_ok[i], sup_s2[i], sup_s3[i]);
      end
    end
  end

  assign main_ok = sup_ok[cdc_pkg::SUPPLY_MAIN];
  assign slow_ok = sup_ok[cdc_pkg::SUPPLY_STANDBY] && sup_ok[cdc_pkg::SUPPLY_CORE];

  // Filters watch their clocks only while the owning supplies are up
  assign ref_if.arm  = main_ok;
  assign slow_if.arm = slow_ok;

  cdc_clock_filter #(
    .MIN_CYC (cdc_pkg::REF_PER_MIN_CYC),
    .MAX_CYC (cdc_pkg::REF_PER_MAX_CYC),
    .GOOD    (cdc_pkg::FILT_GOOD_EDGES),
    .CNT_W   (cdc_pkg::FILT_CNT_W)
  ) u_ref_filter (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .pin   (reference_clock_input),
    .fif   (ref_if.filt)
  );

  cdc_clock_filter #(
    .MIN_CYC (cdc_pkg::SLOW_PER_MIN_CYC),
    .MAX_CYC (cdc_pkg::SLOW_PER_MAX_CYC),
    .GOOD    (cdc_pkg::FILT_GOOD_EDGES),
    .CNT_W   (cdc_pkg::FILT_CNT_W)
  ) u_slow_filter (
    .clk   (clk),
    .rst_b (rst_sync_b),
    .pin   (slow_clock_input),
    .fif   (slow_if.filt)
  );

  // Bus domain follows the main supply
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_domain_run <= 1'b0;
    end else begin
      bus_domain_run <= main_ok; // see [R01] see [R12]
    end
  end

  // Multiplier state: off, locking with output low, running
  always_comb begin
    next_state = state;
    case (state)
      cdc_pkg::GEN_OFF: begin
        if (generator_enable && main_ok) begin
          next_state = cdc_pkg::GEN_LOCKING; // see [R04]
        end
      end
      cdc_pkg::GEN_LOCKING: begin
        if (!generator_enable || !main_ok) begin
          next_state = cdc_pkg::GEN_OFF;
        end else if (ref_if.valid && lock_cnt == cdc_pkg::GEN_LOCK_LAST) begin
          next_state = cdc_pkg::GEN_RUN; // see [R05]
        end
      end
      cdc_pkg::GEN_RUN: begin
        if (!generator_enable || !main_ok) begin
          next_state = cdc_pkg::GEN_OFF; // see [R01]
        end else if (!ref_if.valid) begin
          next_state = cdc_pkg::GEN_LOCKING;
        end
      end
      default: next_state = cdc_pkg::GEN_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= cdc_pkg::GEN_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Lock delay counts only while the reference is valid
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lock_cnt <= '0;
    end else if (state != cdc_pkg::GEN_LOCKING || !ref_if.valid) begin
      lock_cnt <= '0;
    end else if (lock_cnt != cdc_pkg::GEN_LOCK_LAST) begin
      lock_cnt <= lock_cnt + cdc_pkg::GEN_LOCK_W'(1); // see [R05]
    end
  end

  assign gen_running = (state == cdc_pkg::GEN_RUN);

  // Phase accumulator: toggle rate is twice reference times the fixed ratio
  assign acc_sum = {1'b0, acc} + {1'b0, cdc_pkg::GEN_ACC_STEP};
  assign tick    = (acc_sum >= {1'b0, cdc_pkg::GEN_ACC_MOD});

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc <= '0;
    end else if (!gen_running) begin
      acc <= '0;
    end else if (tick) begin
      acc <= cdc_pkg::GEN_ACC_W'(acc_sum - {1'b0, cdc_pkg::GEN_ACC_MOD}); // see [R08]
    end else begin
      acc <= acc_sum[cdc_pkg::GEN_ACC_W-1:0];
    end
  end

  // 48 MHz domain clock, frozen low unless running
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      gen_domain_clk <= 1'b0;
      gen_domain_run <= 1'b0;
    end else begin
      gen_domain_run <= gen_running && main_ok; // see [R01] see [R13]
      if (!gen_running) begin
        gen_domain_clk <= 1'b0; // see [R05]
      end else if (tick) begin
        gen_domain_clk <= !gen_domain_clk; // see [R08] see [R13]
      end
    end
  end

  // Valid flag through two stages toward the register side
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      valid_q1              <= 1'b0;
      generator_clock_valid <= 1'b0;
    end else begin
      valid_q1              <= gen_running;
      generator_clock_valid <= valid_q1; // see [R06] see [R14]
    end
  end

  // 32 KHz domain: gated by supplies and the filter's valid
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      slow_domain_run  <= 1'b0;
      slow_domain_clk  <= 1'b0;
      slow_clock_valid <= 1'b0;
    end else begin
      slow_domain_run  <= slow_ok; // see [R09]
      slow_clock_valid <= slow_if.valid;
      slow_domain_clk  <= slow_ok && slow_if.valid && slow_if.level; // see [R10] see [R11]
    end
  end

  // Checks
  property p_bus_off;
    @(posedge clk) disable iff (!rst_sync_b) !main_ok |=> !bus_domain_run && !gen_domain_run;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("domain runs without main"); // see [R01]

  property p_enable_start;
    @(posedge clk) disable iff (!rst_sync_b)
      (state == cdc_pkg::GEN_OFF && generator_enable && main_ok)
        |=> state == cdc_pkg::GEN_LOCKING;
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("enable did not start"); // see [R04]

  property p_held_low;
    @(posedge clk) disable iff (!rst_sync_b) !gen_running |=> !gen_domain_clk;
  endproperty
  a_held_low: assert property (p_held_low) else $error("48 MHz clock not held low"); // see [R05]

  property p_lock_done;
    @(posedge clk) disable iff (!rst_sync_b)
      (state == cdc_pkg::GEN_LOCKING && generator_enable && main_ok && ref_if.valid
       && lock_cnt == cdc_pkg::GEN_LOCK_LAST) |=> gen_running;
  endproperty
  a_lock_done: assert property (p_lock_done) else $error("lock delay overrun"); // see [R05]

  property p_valid_low;
    @(posedge clk) disable iff (!rst_sync_b) !gen_running |-> ##2 !generator_clock_valid;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("valid set while locking"); // see [R06]

  property p_valid_two;
    @(posedge clk) disable iff (!rst_sync_b)
      $rose(gen_running) |-> !generator_clock_valid ##1 !generator_clock_valid
        ##1 generator_clock_valid;
  endproperty
  a_valid_two: assert property (p_valid_two) else $error("valid not two stages late"); // see [R14]

  property p_toggle;
    @(posedge clk) disable iff (!rst_sync_b)
      (gen_running && tick) |=> gen_domain_clk != $past(gen_domain_clk);
  endproperty
  a_toggle: assert property (p_toggle) else $error("48 MHz clock missed a toggle"); // see [R08]

  property p_slow_run;
    @(posedge clk) disable iff (!rst_sync_b) !slow_ok |=> !slow_domain_run && !slow_domain_clk;
  endproperty
  a_slow_run: assert property (p_slow_run) else $error("32 KHz domain without supply"); // see [R09]

  property p_slow_gate;
    @(posedge clk) disable iff (!rst_sync_b)
      slow_domain_clk |-> $past(slow_if.valid) && $past(slow_if.level);
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("32 KHz clock not gated"); // see [R10]

  c_lock: cover property (@(posedge clk) disable iff (!rst_sync_b) $rose(generator_clock_valid));
  c_relock: cover property (@(posedge clk) disable iff (!rst_sync_b)
    state == cdc_pkg::GEN_RUN ##1 state == cdc_pkg::GEN_LOCKING);
  c_slow: cover property (@(posedge clk) disable iff (!rst_sync_b) $rose(slow_domain_clk));
  c_main_loss: cover property (@(posedge clk) disable iff (!rst_sync_b)
    gen_running ##1 !main_ok);

endmodule

// >>> bench/cdc_clock_source.sv
// Outside clock sources feeding the reference and slow clock pins
`timescale 1ns/1ps
module cdc_clock_source #(
  parameter int REF_HALF_NS  = 35,
  parameter int SLOW_HALF_NS = 15259
) (
  // Switches from the bench
  input  wire logic ref_on,
  input  wire logic slow_on,
  // Clock pins toward the block
  output logic      ref_clk,
  output logic      slow_clk
);
  // Reference oscillator near 14.3 MHz, stands low while switched off
  always begin
    ref_clk = 1'b0;
    wait (ref_on);
    while (ref_on) begin
      #(REF_HALF_NS) ref_clk = 1'b1;
      #(REF_HALF_NS) ref_clk = 1'b0;
    end
  end

  // Watch crystal near 32.768 KHz, stands low while switched off
  always begin
    slow_clk = 1'b0;
    wait (slow_on);
    while (slow_on) begin
      #(SLOW_HALF_NS) slow_clk = 1'b1;
      #(SLOW_HALF_NS) slow_clk = 1'b0;
    end
  end
endmodule

// >>> bench/tb.sv
// Self-checking testbench for the clock domain control block
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin num_errors++; $display("Error at %0t: %s", $time, msg); end end
module tb;
  // Design pins
  logic clk;
  logic rst_b;
  logic main_supply;
  logic standby_supply;
  logic core_supply;
  logic generator_enable;
  logic ref_clk;
  logic slow_clk;
  logic bus_domain_run;
  logic gen_domain_run;
  logic gen_domain_clk;
  logic generator_clock_valid;
  logic slow_domain_run;
  logic slow_domain_clk;
  logic slow_clock_valid;
  // Bench state
  logic ref_on;
  logic slow_on;
  int   num_errors = 0;
  int   num_checks = 0;
  int   n;
  logic leak;
  int   r;

  cdc_clock_control i_dut (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .main_supply           (main_supply),
    .standby_supply        (standby_supply),
    .core_supply           (core_supply),
    .reference_clock_input (ref_clk),
    .slow_clock_input      (slow_clk),
    .generator_enable      (generator_enable),
    .bus_domain_run        (bus_domain_run),
    .gen_domain_run        (gen_domain_run),
    .gen_domain_clk        (gen_domain_clk),
    .generator_clock_valid (generator_clock_valid),
    .slow_domain_run       (slow_domain_run),
    .slow_domain_clk       (slow_domain_clk),
    .slow_clock_valid      (slow_clock_valid)
  );

  cdc_clock_source i_src (
    .ref_on   (ref_on),
    .slow_on  (slow_on),
    .ref_clk  (ref_clk),
    .slow_clk (slow_clk)
  );

  // System clock, running from time zero so the bus clock is good before reset ends
  initial clk = 1'b0;
  always #(cdc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // Output picked by index
  function automatic logic sig(input int w);
    case (w)
      0: return bus_domain_run;
      1: return gen_domain_run;
      2: return generator_clock_valid;
      3: return slow_clock_valid;
      4: return slow_domain_run;
      5: return gen_domain_clk;
      default: return slow_domain_clk;
    endcase
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bounded wait for an output level; flags any high on a quiet output meanwhile
  task automatic wait_sig(input int w, input logic v, input int bound, input int quiet);
    n = 0;
    leak = 1'b0;
    while (1) begin
      if (sig(w) === v) break;
      if (quiet >= 0 && sig(quiet) !== 1'b0) leak = 1'b1;
      if (n == bound) begin
        num_errors++;
        $display("Error at %0t: wait on output %0d timed out", $time, w);
        tally_and_finish();
      end
      @(negedge clk);
      n++;
    end
  endtask

  // Rising edges of an output over a number of cycles
  task automatic count_rise(input int w, input int cycles);
    logic prev;
    prev = sig(w);
    r = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (prev === 1'b0 && sig(w) === 1'b1) r++;
      prev = sig(w);
    end
  endtask

  // Enable while the main supply is down is ignored
  task automatic t_enable_without_main();
    ref_on = 1'b1;
    generator_enable = 1'b1;
    n = 0;
    repeat (1100) begin
      @(negedge clk);
      if ({gen_domain_run, gen_domain_clk} !== 2'h0) n++;
    end
    `CHECK(n, 0, "lock without main supply")
    `CHECK(gen_domain_clk, 1'b0, "gen clock toggled without main")
    `CHECK(generator_clock_valid, 1'b0, "valid without main")
    generator_enable = 1'b0;
  endtask

  // Domain run flags follow their supplies
  task automatic t_supplies();
    main_supply = 1'b1;
    wait_sig(0, 1'b1, 10, 4);
    `CHECK(n, 5, "bus domain start latency")
    standby_supply = 1'b1;
    count_rise(4, 20);
    `CHECK(r, 0, "slow domain ran without core")
    core_supply = 1'b1;
    wait_sig(4, 1'b1, 10, -1);
    `CHECK(n, 5, "slow domain start latency")
  endtask

  // Enable, lock delay with clock held low, valid flag lag and rate
  task automatic t_lock();
    repeat (60) @(negedge clk);
    generator_enable = 1'b1;
    wait_sig(1, 1'b1, 1100, 5);
    `CHECK(leak, 1'b0, "gen clock toggled before lock")
    `CHECK(n >= cdc_pkg::GEN_LOCK_CYCLES && n <= cdc_pkg::GEN_LOCK_CYCLES + 4, 1'b1, "lock delay")
    `CHECK(generator_clock_valid, 1'b0, "valid before domain ran")
    wait_sig(2, 1'b1, 5, -1);
    `CHECK(n, 1, "valid flag lag")
    count_rise(5, 1000);
    `CHECK(r >= 1000 * cdc_pkg::GEN_FREQ_HZ / cdc_pkg::CLK_FREQ_HZ - 1
           && r <= 1000 * cdc_pkg::GEN_FREQ_HZ / cdc_pkg::CLK_FREQ_HZ + 1, 1'b1, "gen rate")
    `CHECK(gen_domain_run, 1'b1, "gen domain stopped")
  endtask

  // Reference lost while running, then regained
  task automatic t_ref_lost();
    ref_on = 1'b0;
    wait_sig(1, 1'b0, 30, -1);
    wait_sig(2, 1'b0, 5, -1);
    `CHECK(n <= 2, 1'b1, "valid kept after reference loss")
    count_rise(5, 50);
    `CHECK(r, 0, "gen clock toggled without reference")
    `CHECK(gen_domain_clk, 1'b0, "gen clock not low")
    ref_on = 1'b1;
    wait_sig(2, 1'b1, 1200, -1);
    `CHECK(gen_domain_run, 1'b1, "relock failed")
  endtask

  // Dropping and raising enable restarts the full lock delay
  task automatic t_reenable();
    generator_enable = 1'b0;
    wait_sig(1, 1'b0, 5, -1);
    wait_sig(2, 1'b0, 5, -1);
    `CHECK(gen_domain_clk, 1'b0, "gen clock not low when disabled")
    generator_enable = 1'b1;
    wait_sig(1, 1'b1, 1100, 2);
    `CHECK(n >= cdc_pkg::GEN_LOCK_CYCLES, 1'b1, "short relock")
    `CHECK(leak, 1'b0, "valid before relock")
  endtask

  // Main supply loss stops bus and 48 MHz domains, slow domain stays
  task automatic t_main_loss();
    main_supply = 1'b0;
    wait_sig(0, 1'b0, 8, -1);
    `CHECK(n, 5, "bus domain stop latency")
    wait_sig(1, 1'b0, 3, -1);
    count_rise(5, 20);
    `CHECK(r, 0, "gen clock without main supply")
    `CHECK(slow_domain_run, 1'b1, "slow domain tied to main")
    generator_enable = 1'b0;
  endtask

  // Slow clock gated low until valid, then passed at its own rate
  task automatic t_slow();
    `CHECK({slow_clock_valid, slow_domain_clk}, 2'h0, "slow domain not held low")
    slow_on = 1'b1;
    wait_sig(3, 1'b1, 20000, 6);
    `CHECK(leak, 1'b0, "slow clock passed before valid")
    count_rise(6, 30518);
    `CHECK(r >= 9 && r <= 11, 1'b1, "slow domain rate")
    standby_supply = 1'b0;
    wait_sig(4, 1'b0, 8, -1);
    count_rise(6, 4000);
    `CHECK(r, 0, "slow clock without standby supply")
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    main_supply = 1'b0;
    standby_supply = 1'b0;
    core_supply = 1'b0;
    generator_enable = 1'b0;
    ref_on = 1'b0;
    slow_on = 1'b0;
    repeat (6) @(negedge clk);
    `CHECK({bus_domain_run, gen_domain_run, gen_domain_clk, generator_clock_valid,
            slow_domain_run, slow_domain_clk, slow_clock_valid}, 7'h00, "outputs in reset")
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    t_enable_without_main();
    t_supplies();
    t_lock();
    t_ref_lost();
    t_reenable();
    t_main_loss();
    t_slow();
    tally_and_finish();
  end
endmodule
